// file: usr_pkg.sv
/*
 * usr_pkg: shared constants and types for the four-bit universal shift
 * register. Assumes nothing beyond a SystemVerilog compiler.
 */
package usr_pkg;

    localparam int unsigned USR_WIDTH = 4;

    // mode codes, first select in bit 1, second select in bit 0
    typedef enum logic [1:0] {
        USR_MODE_LOAD  = 2'h0,
        USR_MODE_RIGHT = 2'h1,
        USR_MODE_LEFT  = 2'h2,
        USR_MODE_HOLD  = 2'h3
    } usr_mode_t;

    localparam logic [USR_WIDTH-1:0] USR_CLEAR_VALUE = 4'h0;

    typedef struct packed {
        logic                 serial_in_left;
        logic                 serial_in_right;
        logic [USR_WIDTH-1:0] parallel_in;
    } usr_data_t;

endpackage : usr_pkg

// file: usr_stage.sv
/*
 * usr_stage: the storage flip-flops of the shift register, with an
 * optional synchronous clear. Assumes one clock and a computed next value.
 */
`timescale 1ns/1ps
module usr_stage #(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // next value and held value
    input  wire logic [WIDTH-1:0] i_nxt_bits,
    output logic      [WIDTH-1:0] o_bits
);

    logic [WIDTH-1:0] bits_ff;

    // rising edge only, clear is synchronous
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            bits_ff <= WIDTH'(usr_pkg::USR_CLEAR_VALUE);
        end else begin
            bits_ff <= i_nxt_bits;
        end
    end

    assign o_bits = bits_ff;

endmodule : usr_stage

// file: usr_shift_reg.sv
/*
 * usr_shift_reg: four-bit universal shift register with parallel load,
 * shift right, shift left and hold chosen by two selects.
 * Assumes selects and data are synchronous to i_sys_clk and settled
 * around each rising edge; the clock itself is never gated upstream.
 * Storage and the optional clear sit in usr_stage.
 */
// Behaviour
// - four stored bits always visible; parallel and two serial inputs.
// - stored bits change only on the rising clock edge.
// - two selects pick the operation; clock is never gated.
// - both selects low: load the four parallel inputs.
// - first low, second high: shift right, top bit from right serial.
// - first high, second low: shift left, bit zero from left serial.
// - both selects high: hold all bits.
`timescale 1ns/1ps
module usr_shift_reg #(
    parameter int unsigned WIDTH = usr_pkg::USR_WIDTH
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // mode selects
    input  wire logic             i_mode_select_first,
    input  wire logic             i_mode_select_second,
    // data inputs
    input  wire logic [WIDTH-1:0] i_parallel_in,
    input  wire logic             i_serial_in_left,
    input  wire logic             i_serial_in_right,
    // stage outputs, bit 0 is stage_out_bit0
    output logic      [WIDTH-1:0] o_stage_out
);

    // decoded mode and the inputs gathered into one carrier
    usr_pkg::usr_mode_t mode;
    usr_pkg::usr_data_t data;

    // held bits, the two neighbour feeds and the next value
    logic [WIDTH-1:0]   cur_bits;
    logic [WIDTH-1:0]   upper_bits;
    logic [WIDTH-1:0]   lower_bits;
    logic [WIDTH-1:0]   nxt_bits;

    // select pair to mode code, first select is the high bit
    function automatic usr_pkg::usr_mode_t mode_of(
        input logic first,
        input logic second
    );
        usr_pkg::usr_mode_t m;

        m = usr_pkg::usr_mode_t'({first, second});

        return m;
    endfunction : mode_of

    // pins that travel together, packed as one word; the carrier is
    // sized by the package width, so WIDTH must stay at that value
    function automatic usr_pkg::usr_data_t gather_inputs(
        input logic             sl,
        input logic             sr,
        input logic [WIDTH-1:0] d
    );
        usr_pkg::usr_data_t g;

        g.serial_in_left  = sl;
        g.serial_in_right = sr;
        g.parallel_in     = d;

        return g;
    endfunction : gather_inputs

    // right-shift source of one stage: its upper neighbour, or the
    // right serial input for the top stage
    function automatic logic upper_of(
        input logic [WIDTH-1:0] q,
        input logic             sr,
        input int unsigned      pos
    );
        logic b;

        if (pos == WIDTH - 1) begin
            b = sr;
        end else begin
            b = q[pos + 1];
        end

        return b;
    endfunction : upper_of

    // left-shift source of one stage: its lower neighbour, or the
    // left serial input for stage zero
    function automatic logic lower_of(
        input logic [WIDTH-1:0] q,
        input logic             sl,
        input int unsigned      pos
    );
        logic b;

        if (pos == 0) begin
            b = sl;
        end else begin
            b = q[pos - 1];
        end

        return b;
    endfunction : lower_of

    // right-shift sources of all stages side by side
    function automatic logic [WIDTH-1:0] right_feed(
        input logic [WIDTH-1:0] q,
        input logic             sr
    );
        logic [WIDTH-1:0] f;

        f = q;
        for (int unsigned i = 0; i < WIDTH; i++) begin
            f[i] = upper_of(q, sr, i);
        end

        return f;
    endfunction : right_feed

    // left-shift sources of all stages side by side
    function automatic logic [WIDTH-1:0] left_feed(
        input logic [WIDTH-1:0] q,
        input logic             sl
    );
        logic [WIDTH-1:0] f;

        f = q;
        for (int unsigned i = 0; i < WIDTH; i++) begin
            f[i] = lower_of(q, sl, i);
        end

        return f;
    endfunction : left_feed

    // one stage is a four-way choice; the clock is common to all
    function automatic logic stage_next(
        input usr_pkg::usr_mode_t m,
        input logic               self_bit,
        input logic               load_bit,
        input logic               upper_bit,
        input logic               lower_bit
    );
        logic b;

        b = self_bit;

        case (m)
            usr_pkg::USR_MODE_LOAD: begin
                b = load_bit;
            end
            usr_pkg::USR_MODE_RIGHT: begin
                b = upper_bit;
            end
            usr_pkg::USR_MODE_LEFT: begin
                b = lower_bit;
            end
            usr_pkg::USR_MODE_HOLD: begin
                b = self_bit;
            end
            default: begin
                // undriven selects keep the contents rather than guess
                b = self_bit;
            end
        endcase

        return b;
    endfunction : stage_next

    // every stage in parallel, so all bits move on the same edge;
    // no stage sees a neighbour's new value within one cycle
    function automatic logic [WIDTH-1:0] next_bits(
        input usr_pkg::usr_mode_t m,
        input logic [WIDTH-1:0]   q,
        input logic [WIDTH-1:0]   d,
        input logic [WIDTH-1:0]   up,
        input logic [WIDTH-1:0]   low
    );
        logic [WIDTH-1:0] r;

        r = q;

        for (int unsigned i = 0; i < WIDTH; i++) begin
            r[i] = stage_next(m, q[i], d[i], up[i], low[i]);
        end

        return r;
    endfunction : next_bits

    always_comb begin
        // selects steer data, never the clock
        mode       = mode_of(i_mode_select_first,
                             i_mode_select_second);

        data       = gather_inputs(i_serial_in_left,
                                   i_serial_in_right,
                                   i_parallel_in);

        // both feeds are formed every cycle; the mode picks one
        upper_bits = right_feed(cur_bits, data.serial_in_right);
        lower_bits = left_feed(cur_bits, data.serial_in_left);

        nxt_bits   = next_bits(mode,
                               cur_bits,
                               data.parallel_in,
                               upper_bits,
                               lower_bits);
    end

    // the flip-flops live in their own module with the clear
    usr_stage #(
        .WIDTH (WIDTH)
    ) u_stage (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_nxt_bits (nxt_bits),
        .o_bits     (cur_bits)
    );

    // outputs come straight from the stage flip-flops
    assign o_stage_out = cur_bits;

endmodule : usr_shift_reg

// file: usr_monitor.sv
/*
 * usr_monitor: concurrent checks and covers on the ports of
 * usr_shift_reg, bound at the foot of this file.
 * Assumes it sees only those ports and that i_rst_n is a synchronous
 * active-low clear sampled on the rising edge.
 */
`timescale 1ns/1ps
module usr_monitor #(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // mode selects
    input  wire logic             i_mode_select_first,
    input  wire logic             i_mode_select_second,
    // data inputs
    input  wire logic [WIDTH-1:0] i_parallel_in,
    input  wire logic             i_serial_in_left,
    input  wire logic             i_serial_in_right,
    // stage outputs
    input  wire logic [WIDTH-1:0] o_stage_out
);

    wire logic [1:0] m = {i_mode_select_first, i_mode_select_second};
    wire logic [3:0] q = o_stage_out;
    wire logic [3:0] d = i_parallel_in;
    wire logic       l = i_serial_in_left;
    wire logic       r = i_serial_in_right;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    a_load_ok: assert property (
        m == 2'h0 |=> q == $past(d)
    ) else $error("load did not take the parallel inputs");

    a_right_ok: assert property (
        m == 2'h1 |=> q == {$past(r), $past(q[3:1])}
    ) else $error("right shift gave wrong bits");

    a_left_ok: assert property (
        m == 2'h2 |=> q == {$past(q[2:0]), $past(l)}
    ) else $error("left shift gave wrong bits");

    a_hold_ok: assert property (
        m == 2'h3 |=> $stable(q)
    ) else $error("hold changed the bits");

    a_clear_ok: assert property (
        disable iff (1'b0) !i_rst_n |=> q == 4'h0
    ) else $error("clear did not empty the bits");

    a_load_then_hold: assert property (
        m == 2'h0 ##1 (m == 2'h3)[*2] |=> q == $past(d, 3)
    ) else $error("loaded value not kept through hold");

    a_right_left: assert property (
        m == 2'h1 ##1 m == 2'h2 |=> q[3:1] == $past(q[3:1], 2)
    ) else $error("right then left did not restore bits");

    a_four_right: assert property (
        (m == 2'h1)[*4] |=>
            q == {$past(r), $past(r, 2), $past(r, 3), $past(r, 4)}
    ) else $error("four right shifts lost serial bits");

    cover property (m == 2'h0 ##1 m == 2'h1);
    cover property ((m == 2'h2)[*4]);
    cover property ((m == 2'h3)[*2]);
    cover property (disable iff (1'b0) !i_rst_n ##1 i_rst_n);

endmodule : usr_monitor

bind usr_shift_reg usr_monitor #(
    .WIDTH (WIDTH)
) u_mon (
    .i_sys_clk            (i_sys_clk),
    .i_rst_n              (i_rst_n),
    .i_mode_select_first  (i_mode_select_first),
    .i_mode_select_second (i_mode_select_second),
    .i_parallel_in        (i_parallel_in),
    .i_serial_in_left     (i_serial_in_left),
    .i_serial_in_right    (i_serial_in_right),
    .o_stage_out          (o_stage_out)
);

// file: usr_partner.sv
/*
 * usr_partner: the surrounding logic that drives selects and data,
 * one command word {first, second, left, right, parallel} at a time.
 * Assumes the bench changes i_cmd away from the falling edge.
 */
`timescale 1ns/1ps
module usr_partner (
    // clock
    input  wire logic       i_sys_clk,
    // command from the bench
    input  wire logic [7:0] i_cmd,
    // command as presented to the register
    output logic      [7:0] o_cmd = 8'h00
);

    // half a period of setup before the rising edge that takes it
    always @(negedge i_sys_clk) begin
        o_cmd <= i_cmd;
    end

endmodule : usr_partner

// file: tb_top.sv
/*
 * tb_top: directed bench for usr_shift_reg with a bit-level model.
 * Assumes usr_partner presents each command from a falling edge and
 * that the checker binds itself from its own file.
 */
`timescale 1ns/1ps
module tb_top;
    logic       clk         = 1'b0;
    logic       rst_n       = 1'b0;
    logic [7:0] cmd         = 8'h00;
    logic [7:0] pc;
    logic [3:0] q;
    logic [3:0] mdl         = 4'h0;
    int         mismatches  = 0;
    int         checks_done = 0;

    always #5 clk = ~clk;

    usr_partner p (
        .i_sys_clk (clk),
        .i_cmd     (cmd),
        .o_cmd     (pc)
    );

    usr_shift_reg uut (
        .i_sys_clk            (clk),
        .i_rst_n              (rst_n),
        .i_mode_select_first  (pc[7]),
        .i_mode_select_second (pc[6]),
        .i_parallel_in        (pc[3:0]),
        .i_serial_in_left     (pc[5]),
        .i_serial_in_right    (pc[4]),
        .o_stage_out          (q)
    );

    task automatic chk(
        input logic [3:0] got,
        input logic [3:0] exp
    );
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch stage_out exp %h seen %h", exp, got);
        end
    endtask : chk

    // new inputs appear at the falling edge and must not move the
    // outputs there; only the following rising edge may
    task automatic step(input logic [7:0] c);
        cmd = c;
        @(negedge clk);
        #1;
        chk(q, mdl);
        @(posedge clk);
        #1;
        case (c[7:6])
            2'h0: mdl = c[3:0];
            2'h1: mdl = {c[4], mdl[3:1]};
            2'h2: mdl = {mdl[2:0], c[5]};
            2'h3: mdl = mdl;
            default: mdl = mdl;
        endcase
        chk(q, mdl);
    endtask : step

    task automatic sc_modes;
        step(8'h0A);
        step(8'h50);
        step(8'h85);
        step(8'h0C);
        step(8'hFF);
        step(8'hF0);
    endtask : sc_modes

    // four right shifts then four left, serial bits differing per end
    task automatic sc_serial;
        for (int i = 0; i < 8; i++) begin
            step({i[2], ~i[2], i[1], i[0], 4'h0});
        end
    endtask : sc_serial

    task automatic sc_clear;
        step(8'h0F);
        step(8'hC0);
        @(negedge clk);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk(q, 4'h0);
        @(negedge clk);
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        mdl = 4'h0;
        chk(q, mdl);
        step(8'h50);
    endtask : sc_clear
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        sc_modes();
        sc_serial();
        sc_clear();
        conclude();
    end
endmodule : tb_top
